// ### rtl/reset_sequencer_shadow_regs.v
// Reset and clock bring-up sequencer with an AXI4-Lite register file of plain, status and one pending/active shadow pair.
// Assumes all domains share aclk here; the board keeps the reference clock running.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "reset_seq_consts.vh"
module reset_sequencer_shadow_regs
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire boot_auto_start,
    input wire [1:0] boot_clock_sel,
    input wire fast_pll_lock,
    output reg [3:0] fast_pll_mult_ff,
    output reg controller_clock_sel_ff,
    output reg [1:0] controller_clock_src_ff,
    output reg controller_rst_ff,
    output reg [1:0] synth_clock_src_ff,
    output reg [1:0] frame_clock_src_ff,
    output reg frame_buffer_clock_en_ff,
    output wire domain_rst,
    output reg [31:0] active_ctrl_ff
);
    // Register images, write holding registers and bring-up state.
    reg [31:0] host_ctrl_ff;
    reg [31:0] clk_sel_ff;
    reg [31:0] pend_ctrl_ff;
    reg [1:0] w1c_ff;
    reg soft_req_ff;
    reg aw_held_ff;
    reg w_held_ff;
    reg [7:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg [1:0] boot_sel_ff;
    reg boot_auto_ff;
    reg was_in_rst_ff;
    reg [7:0] phase_ff;
    // Views of the write channel and of the two status words.
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire wr_fire;
    wire [31:0] ro_status;
    wire [31:0] w1c_word;

    // Merges byte lanes of a write into an old value.
    // Lanes whose strobe is low keep the value they had.
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
    endfunction

    // ==========================================================
    // Domain reset stretcher
    // Hardware reset or a software request holds the domain for 64 cycles.
    // The request is synchronised inside the stretcher, so it must stay up
    // until the domain has been seen in reset, or a short pulse could be lost.
    domain_reset_stretch u_stretch
    (
        .clk(aclk),
        .hard_rst_n(aresetn),
        .soft_req(soft_req_ff),
        .domain_rst_ff(domain_rst)
    );

    // ==========================================================
    // AXI write channel capture
    // Address and data are held independently, in either order.
    // A held half is not taken again until its response has been accepted.
    // This keeps a fast master from replacing an address still waiting for data.
    // The response is registered, so it follows the later half by one edge.
    assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_ff & ~s_axi_bvalid;
    assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
    assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
    assign wr_fire = (aw_held_ff | (s_axi_awvalid & s_axi_awready))
        & (w_held_ff | (s_axi_wvalid & s_axi_wready));

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else
        begin
            if (wr_fire)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (wr_addr)
                    `OFS_HOST_CONTROL, `OFS_CLOCK_SELECT, `OFS_PEND_CTRL, `OFS_ACT_CTRL,
                    `OFS_STATUS_W1C, `OFS_STATUS_RO: s_axi_bresp <= `RESP_OKAY;
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            else
            begin
                if (s_axi_awvalid && s_axi_awready)
                begin
                    aw_held_ff <= 1'b1;
                    aw_addr_ff <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready)
                begin
                    w_held_ff <= 1'b1;
                    w_data_ff <= s_axi_wdata;
                    w_strb_ff <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register file with pending, active, plain and clearable types
    // Hardware reset returns all to their defaults; software reset clears only active and status.
    // The update strobe is ignored while the domain is held in reset.
    // The active half therefore stays at its default for the whole stretch.
    // Status flags give the setting event priority over a clearing write.
    // An event in the same cycle as a clear is therefore never lost.
    // Plain read-only status is built from live state and has no storage here.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            host_ctrl_ff <= `RST_HOST_CONTROL;              // [RULE_03]
            clk_sel_ff <= `RST_CLOCK_SELECT;
            pend_ctrl_ff <= `RST_PEND_CTRL;                 // [RULE_14]
            active_ctrl_ff <= `RST_ACT_CTRL;
            w1c_ff <= 2'b00;
            soft_req_ff <= 1'b0;
        end
        else
        begin
            // A request stays up until the stretcher has taken the domain down.
            if (soft_req_ff && domain_rst)
                soft_req_ff <= 1'b0;
            if (wr_fire && wr_addr == `OFS_HOST_CONTROL)
            begin
                host_ctrl_ff <= merge(host_ctrl_ff, wr_data, wr_strb) & 32'h0000_0003;
                if (wr_strb[0] && !wr_data[`BIT_SOFT_RESET])
                    soft_req_ff <= 1'b1;                    // [RULE_09]
            end
            if (wr_fire && wr_addr == `OFS_CLOCK_SELECT)
                clk_sel_ff <= merge(clk_sel_ff, wr_data, wr_strb) & 32'h0000_000F;
            if (wr_fire && wr_addr == `OFS_PEND_CTRL)
                pend_ctrl_ff <= merge(pend_ctrl_ff, wr_data, wr_strb); // [RULE_14]
            // Software reset clears active half and status, pending is kept.
            if (soft_req_ff)
            begin
                active_ctrl_ff <= `RST_ACT_CTRL;            // [RULE_11] [RULE_13]
                w1c_ff <= 2'b00;                            // [RULE_15]
            end
            else
            begin
                if (wr_fire && wr_addr == `OFS_HOST_CONTROL && wr_strb[0]
                    && wr_data[`BIT_UPDATE]
                    && !domain_rst)                         // [RULE_13]
                    active_ctrl_ff <= pend_ctrl_ff;         // [RULE_12]
                // Set wins over a write-one clear in the same cycle.
                w1c_ff[`BIT_ST_LOCK_SEEN] <= (fast_pll_lock & ~domain_rst)
                    | (w1c_ff[`BIT_ST_LOCK_SEEN] & ~(wr_fire && wr_addr == `OFS_STATUS_W1C
                    && wr_strb[0] && wr_data[`BIT_ST_LOCK_SEEN])); // [RULE_15]
                w1c_ff[`BIT_ST_SOFT_DONE] <= (was_in_rst_ff & ~domain_rst)
                    | (w1c_ff[`BIT_ST_SOFT_DONE] & ~(wr_fire && wr_addr == `OFS_STATUS_W1C
                    && wr_strb[0] && wr_data[`BIT_ST_SOFT_DONE]));
            end
            // The reset bit clears itself to zero when the stretch ends.
            if (was_in_rst_ff && !domain_rst)
                host_ctrl_ff[`BIT_SOFT_RESET] <= 1'b0;      // [RULE_10]
        end
    end

    // ==========================================================
    // Bring-up sequence
    // Straps are caught during reset; clock switch waits for lock.
    // The straps are caught once, on the first edge out of hardware reset.
    // Later strap movement cannot redirect a running controller clock.
    // The multiplier and the frame-buffer clock enable are rewritten every cycle.
    // A software reset therefore never disturbs them.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            boot_sel_ff <= 2'b00;
            boot_auto_ff <= 1'b0;
            was_in_rst_ff <= 1'b1;
            phase_ff <= 8'h00;
            fast_pll_mult_ff <= `FAST_PLL_MULT;             // [RULE_06]
            controller_clock_sel_ff <= 1'b0;                // [RULE_05]
            controller_clock_src_ff <= 2'b00;
            controller_rst_ff <= 1'b1;
            synth_clock_src_ff <= 2'b00;
            frame_clock_src_ff <= 2'b00;
            frame_buffer_clock_en_ff <= 1'b1;
        end
        else
        begin
            was_in_rst_ff <= domain_rst;
            fast_pll_mult_ff <= `FAST_PLL_MULT;             // [RULE_18]
            frame_buffer_clock_en_ff <= 1'b1;               // [RULE_20]
            synth_clock_src_ff <= clk_sel_ff[`FLD_SYNTH_SEL_LSB +: 2]; // [RULE_19]
            frame_clock_src_ff <= clk_sel_ff[`FLD_FRAME_SEL_LSB +: 2]; // [RULE_19]
            if (phase_ff == 8'h00)
            begin
                boot_sel_ff <= boot_clock_sel;
                boot_auto_ff <= boot_auto_start;
                phase_ff <= 8'h01;
            end
            if (domain_rst)
            begin
                controller_rst_ff <= 1'b1;
                if (phase_ff == 8'h01)
                    controller_clock_sel_ff <= 1'b0;        // [RULE_05]
            end
            else
            begin
                if (fast_pll_lock && !controller_clock_sel_ff)
                begin
                    controller_clock_sel_ff <= 1'b1;        // [RULE_07]
                    controller_clock_src_ff <= boot_sel_ff;
                end
                if (controller_clock_sel_ff)
                    controller_rst_ff <= ~(boot_auto_ff
                        | host_ctrl_ff[`BIT_CTRL_ENABLE]);  // [RULE_08]
            end
        end
    end

    // ==========================================================
    // Read channel
    // Read-only status has no write path at all.
    // Read data are registered, so a read answers one edge after its address.
    // Unmapped addresses answer with an error response and zero data.
    // Writes to the read-only words are answered with OKAY and change nothing.
    assign ro_status = {24'h00_0000, 2'b00, controller_clock_src_ff, fast_pll_lock,
        controller_clock_sel_ff, controller_rst_ff, domain_rst}; // [RULE_16]
    assign w1c_word = {30'h0000_0000, w1c_ff};
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
                `OFS_HOST_CONTROL: s_axi_rdata <= host_ctrl_ff;
                `OFS_CLOCK_SELECT: s_axi_rdata <= clk_sel_ff;
                `OFS_PEND_CTRL: s_axi_rdata <= pend_ctrl_ff;
                `OFS_ACT_CTRL: s_axi_rdata <= active_ctrl_ff;
                `OFS_STATUS_W1C: s_axi_rdata <= w1c_word;
                `OFS_STATUS_RO: s_axi_rdata <= ro_status;
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

// ### rtl/reset_seq_consts.vh
// Constants for the reset and clock bring-up sequencer and its register file.
// Assumes one clock at 200 MHz and a synchronous active-low reset.
// What this block and the board do
// RULE_01: Board holds the reset pin low at least 1 us after supplies settle.
// RULE_02: Board keeps the reference timing clock running during and after reset.
// RULE_03: Hardware reset returns every register, pending halves too, to default.
// RULE_04: Each domain holds its internal reset 64 own-clock cycles after release.
// RULE_05: Controller clock runs from the reference clock during the post-reset period.
// RULE_06: Fast PLL is commanded to ten times the reference clock after reset.
// RULE_07: Controller clock switches to bootstrap choice only after fast PLL lock.
// RULE_08: Controller starts if bootstrap auto-start, else held until register enables it.
// RULE_09: Writing zero to the software-reset bit starts a software reset.
// RULE_10: Software-reset bit is cleared to zero by hardware once the sequence completes.
// RULE_11: Software reset clears active halves and status, keeps pending and plain registers.
// RULE_12: Active half copies pending half on an update event at its domain edge.
// RULE_13: Only active contents drive behaviour; both resets clear active bits.
// RULE_14: Pending bits clear only on hardware reset; software may overwrite anytime.
// RULE_15: Clearable status bits clear on write-one and on both resets.
// RULE_16: Writes to plain read-only status bits change nothing.
// RULE_17: Software reset holds each domain in reset 64 own cycles, then resumes.
// RULE_18: Software reset leaves analog PLL, synthesizer, receiver, converter, meter alone.
// RULE_19: Output-side synth and frame PLL clock sources come from a host register.
// RULE_20: Frame-buffer clock is always enabled since it clocks internal FIFOs.
// RULE_21: Reset release is synchronised into each domain before the stretch counter.
`ifndef RESET_SEQ_CONSTS_VH
`define RESET_SEQ_CONSTS_VH

// Register byte offsets.
`define OFS_HOST_CONTROL 8'h00
`define OFS_CLOCK_SELECT 8'h04
`define OFS_PEND_CTRL 8'h08
`define OFS_ACT_CTRL 8'h0C
`define OFS_STATUS_W1C 8'h10
`define OFS_STATUS_RO 8'h14

// Host control fields.
`define BIT_SOFT_RESET 0
`define BIT_CTRL_ENABLE 1
`define BIT_UPDATE 2

// Clock select fields.
`define FLD_SYNTH_SEL_LSB 0
`define FLD_FRAME_SEL_LSB 2

// Clearable status fields.
`define BIT_ST_LOCK_SEEN 0
`define BIT_ST_SOFT_DONE 1

// Read-only status fields.
`define BIT_RO_DOMAIN_RST 0
`define BIT_RO_CTRL_RST 1
`define BIT_RO_ON_FAST 2
`define BIT_RO_LOCK 3
`define BIT_RO_PHASE_LSB 4

// Reset values.
`define RST_HOST_CONTROL 32'h0000_0001
`define RST_CLOCK_SELECT 32'h0000_0000
`define RST_PEND_CTRL 32'h0000_0000
`define RST_ACT_CTRL 32'h0000_0000

// Timing counts.
`define STRETCH_CYCLES 7'h40
`define FAST_PLL_MULT 4'hA

// AXI responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### rtl/domain_reset_stretch.v
// One clock domain's reset stretcher: synchronises a release and holds reset for 64 cycles.
// Assumes the request input is a level in or near this domain's clock.
`timescale 1ns/1ps
`include "reset_seq_consts.vh"
module domain_reset_stretch
(
    input wire clk,
    input wire hard_rst_n,
    input wire soft_req,
    output reg domain_rst_ff
);
    reg sync1_ff;
    reg sync2_ff;
    reg [6:0] cnt_ff;

    // ==========================================================
    // Release synchroniser and stretch counter
    // Two flops bring the release into this domain before counting starts.
    always @(posedge clk)
    begin
        if (!hard_rst_n)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            cnt_ff <= 7'h00;
            domain_rst_ff <= 1'b1;
        end
        else
        begin
            sync1_ff <= ~soft_req;                          // [RULE_21]
            sync2_ff <= sync1_ff;
            if (!sync2_ff)
            begin
                cnt_ff <= 7'h00;
                domain_rst_ff <= 1'b1;
            end
            else if (cnt_ff != `STRETCH_CYCLES)
            begin
                cnt_ff <= cnt_ff + 7'h01;                   // [RULE_04] [RULE_17]
                domain_rst_ff <= 1'b1;
            end
            else
                domain_rst_ff <= 1'b0;
        end
    end
endmodule

// ### tb/pll_lock_model.sv
// Board-side model of the fast PLL lock indication.
// Assumes aclk stands in for the reference clock and runs throughout.
`timescale 1ns/1ps
module pll_lock_model
#(
    parameter LOCK_DELAY = 20
)
(
    input wire aclk,
    input wire aresetn,
    input wire lock_en,
    output reg fast_pll_lock
);
    reg [7:0] lock_cnt_ff;
    // Lock is lost in reset or when disabled, then returns after a delay.
    always @(posedge aclk)
    begin
        if (!aresetn || !lock_en)
        begin
            lock_cnt_ff <= 8'h00;
            fast_pll_lock <= 1'b0;
        end
        else if (lock_cnt_ff == LOCK_DELAY)
            fast_pll_lock <= 1'b1;
        else
            lock_cnt_ff <= lock_cnt_ff + 8'h01;
    end
endmodule

// ### tb/reset_seq_checker.sv
// Concurrent checks on the reset sequencer outputs.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/1ps
`include "reset_seq_consts.vh"
module reset_seq_checker
(
    input wire aclk,
    input wire aresetn,
    input wire fast_pll_lock,
    input wire boot_auto_start,
    input wire [1:0] boot_clock_sel,
    input wire [3:0] fast_pll_mult_ff,
    input wire controller_clock_sel_ff,
    input wire [1:0] controller_clock_src_ff,
    input wire controller_rst_ff,
    input wire frame_buffer_clock_en_ff,
    input wire domain_rst,
    input wire [31:0] active_ctrl_ff
);
    // ====================
    // Helpers
    reg [6:0] since_rel_ff;
    reg [7:0] run_ff;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Count edges since release and the length of the current domain reset.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            since_rel_ff <= 7'h00;
            run_ff <= 8'h00;
        end
        else
        begin
            if (since_rel_ff != 7'h7F)
                since_rel_ff <= since_rel_ff + 7'h01;
            if (!domain_rst)
                run_ff <= 8'h00;
            else if (run_ff != 8'hFF)
                run_ff <= run_ff + 8'h01;
        end
    end
    // ====================
    // Properties
    sequence s_stretch_done;
        $fell(domain_rst);
    endsequence
    property p_hw_stretch;
        since_rel_ff <= 7'h40 |-> domain_rst;
    endproperty
    a_hw_stretch: assert property (p_hw_stretch) else $error("domain reset short");
    property p_stretch_len;
        s_stretch_done |-> run_ff >= 8'h40;
    endproperty
    a_stretch_len: assert property (p_stretch_len) else $error("stretch short");
    property p_stretch_end;
        run_ff <= 8'h50;
    endproperty
    a_stretch_end: assert property (p_stretch_end) else $error("stretch long");
    property p_ref_first;
        since_rel_ff <= 7'h40 |-> !controller_clock_sel_ff;
    endproperty
    a_ref_first: assert property (p_ref_first) else $error("early clock switch");
    property p_lock_first;
        $rose(controller_clock_sel_ff) |-> $past(fast_pll_lock);
    endproperty
    a_lock_first: assert property (p_lock_first) else $error("switch before lock");
    property p_switch_src;
        controller_clock_sel_ff |-> controller_clock_src_ff == boot_clock_sel;
    endproperty
    a_switch_src: assert property (p_switch_src) else $error("wrong clock source");
    property p_switch_soon;
        fast_pll_lock && !domain_rst |-> ##[0:8] controller_clock_sel_ff;
    endproperty
    a_switch_soon: assert property (p_switch_soon) else $error("no switch");
    property p_ctrl_hold;
        !controller_rst_ff |-> controller_clock_sel_ff;
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("controller ran early");
    property p_auto_go;
        controller_clock_sel_ff && boot_auto_start && !domain_rst |-> ##[0:8] !controller_rst_ff;
    endproperty
    a_auto_go: assert property (p_auto_go) else $error("no auto start");
    property p_active_clear;
        domain_rst && run_ff >= 8'h04 |-> active_ctrl_ff == `RST_ACT_CTRL;
    endproperty
    a_active_clear: assert property (p_active_clear) else $error("active kept");
    property p_fixed;
        fast_pll_mult_ff == `FAST_PLL_MULT && frame_buffer_clock_en_ff;
    endproperty
    a_fixed: assert property (p_fixed) else $error("pll or fb clock wrong");
endmodule
bind reset_sequencer_shadow_regs reset_seq_checker chk_i (.aclk, .aresetn, .fast_pll_lock,
    .boot_auto_start, .boot_clock_sel, .fast_pll_mult_ff, .controller_clock_sel_ff,
    .controller_clock_src_ff, .controller_rst_ff, .frame_buffer_clock_en_ff, .domain_rst,
    .active_ctrl_ff);

// ### tb/reset_sequencer_shadow_regs_tb.sv
// Self-checking bench for the reset sequencer over AXI4-Lite.
// Assumes the lock model stands for the board side.
`timescale 1ns/1ps
`include "reset_seq_consts.vh"
module reset_sequencer_shadow_regs_tb;
    logic aclk = 1'b0, aresetn = 1'b0, lock_en = 1'b1, boot_auto_start = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0] boot_clock_sel = 2'h2;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic fast_pll_lock, controller_clock_sel_ff, controller_rst_ff;
    logic frame_buffer_clock_en_ff, domain_rst;
    logic [1:0] s_axi_bresp, s_axi_rresp, controller_clock_src_ff;
    logic [1:0] synth_clock_src_ff, frame_clock_src_ff;
    logic [3:0] fast_pll_mult_ff;
    logic [31:0] s_axi_rdata, active_ctrl_ff;
    integer num_errors = 0, num_checks = 0, i;
    reset_sequencer_shadow_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .boot_auto_start, .boot_clock_sel, .fast_pll_lock, .fast_pll_mult_ff,
        .controller_clock_sel_ff, .controller_clock_src_ff, .controller_rst_ff,
        .synth_clock_src_ff, .frame_clock_src_ff, .frame_buffer_clock_en_ff,
        .domain_rst, .active_ctrl_ff);
    pll_lock_model board (.aclk, .aresetn, .lock_en, .fast_pll_lock);
    // Reference clock runs during and after reset.
    always #2.5 aclk = ~aclk;
    // ====================
    // Tasks
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        reg aw_p, w_p;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            aw_p = 1'b1;
            w_p = 1'b1;
            while (aw_p || w_p)
            begin
                @(posedge aclk);
                if (aw_p && s_axi_awready === 1'b1)
                begin
                    aw_p = 1'b0;
                    s_axi_awvalid <= 1'b0;
                end
                if (w_p && s_axi_wready === 1'b1)
                begin
                    w_p = 1'b0;
                    s_axi_wvalid <= 1'b0;
                end
            end
            do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, er);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do @(posedge aclk); while (s_axi_arready !== 1'b1);
            s_axi_arvalid <= 1'b0;
            do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
            s_axi_rready <= 1'b0;
            chk(s_axi_rresp, er);
            if (er == `RESP_OKAY)
                chk(s_axi_rdata, e);
        end
    endtask
    task report_and_stop;
        begin
            if (num_errors == 0 && num_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // ====================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_HOST_CONTROL, `RST_HOST_CONTROL, `RESP_OKAY);
        rd(`OFS_PEND_CTRL, `RST_PEND_CTRL, `RESP_OKAY);
        chk(fast_pll_mult_ff, `FAST_PLL_MULT);
        chk(frame_buffer_clock_en_ff, 1'b1);
        for (i = 0; i < 400 && controller_clock_sel_ff !== 1'b1; i = i + 1) @(posedge aclk);
        chk(controller_clock_src_ff, 2'h2);
        chk(controller_rst_ff, 1'b1);
        wr(`OFS_HOST_CONTROL, 32'h0000_0003, `RESP_OKAY);
        wr(`OFS_STATUS_RO, 32'hFFFF_FFFF, `RESP_OKAY);
        rd(`OFS_STATUS_RO, 32'h0000_002C, `RESP_OKAY);
        chk(controller_rst_ff, 1'b0);
        wr(`OFS_PEND_CTRL, 32'hA5A5_5A5A, `RESP_OKAY);
        wr(`OFS_ACT_CTRL, 32'hFFFF_FFFF, `RESP_OKAY);
        rd(`OFS_ACT_CTRL, 32'h0000_0000, `RESP_OKAY);
        wr(`OFS_HOST_CONTROL, 32'h0000_0007, `RESP_OKAY);
        chk(active_ctrl_ff, 32'hA5A5_5A5A);
        rd(`OFS_HOST_CONTROL, 32'h0000_0003, `RESP_OKAY);
        wr(`OFS_CLOCK_SELECT, 32'h0000_000E, `RESP_OKAY);
        @(posedge aclk);
        chk({frame_clock_src_ff, synth_clock_src_ff}, 4'hE);
        lock_en <= 1'b0;
        repeat (2) @(posedge aclk);
        wr(`OFS_STATUS_W1C, 32'h0000_0001, `RESP_OKAY);
        rd(`OFS_STATUS_W1C, 32'h0000_0002, `RESP_OKAY);
        lock_en <= 1'b1;
        wr(`OFS_HOST_CONTROL, 32'h0000_0002, `RESP_OKAY);
        for (i = 0; i < 20 && domain_rst !== 1'b1; i = i + 1) @(posedge aclk);
        chk(domain_rst, 1'b1);
        wr(`OFS_HOST_CONTROL, 32'h0000_0007, `RESP_OKAY);
        for (i = 0; i < 300 && domain_rst !== 1'b0; i = i + 1) @(posedge aclk);
        chk(domain_rst, 1'b0);
        rd(`OFS_HOST_CONTROL, 32'h0000_0002, `RESP_OKAY);
        rd(`OFS_ACT_CTRL, 32'h0000_0000, `RESP_OKAY);
        rd(`OFS_PEND_CTRL, 32'hA5A5_5A5A, `RESP_OKAY);
        rd(`OFS_CLOCK_SELECT, 32'h0000_000E, `RESP_OKAY);
        rd(`OFS_STATUS_W1C, 32'h0000_0003, `RESP_OKAY);
        wr(`OFS_STATUS_W1C, 32'h0000_0002, `RESP_OKAY);
        rd(`OFS_STATUS_W1C, 32'h0000_0001, `RESP_OKAY);
        wr(8'h20, 32'h0000_0001, `RESP_SLVERR);
        rd(8'h20, 32'h0000_0000, `RESP_SLVERR);
        aresetn <= 1'b0;
        boot_auto_start <= 1'b1;
        boot_clock_sel <= 2'h1;
        repeat (200) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_PEND_CTRL, `RST_PEND_CTRL, `RESP_OKAY);
        rd(`OFS_CLOCK_SELECT, `RST_CLOCK_SELECT, `RESP_OKAY);
        for (i = 0; i < 400 && controller_rst_ff !== 1'b0; i = i + 1) @(posedge aclk);
        chk(controller_rst_ff, 1'b0);
        chk(controller_clock_src_ff, 2'h1);
        report_and_stop;
    end
    // Watchdog cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge aclk);
        num_errors = num_errors + 1;
        report_and_stop;
    end
endmodule
